/* bsfp_top.sv */
`timescale 1ns/100ps
`include "bsfp_map.svh"
module bsfp_top
  import bsfp_pkg::*;
#(
  parameter int unsigned HICCUP_CYCLES = (`BSFP_HICCUP_MS * 1000000) / `BSFP_CLK_NS
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic enable_write,
  input wire logic enable_wdata,
  input wire logic drop_ovp_enable,
  input wire logic overcurrent_retry_mode,
  input wire logic adc_enable_req,
  input wire logic flag_clear,
  input wire logic [6:0] flag_clear_mask,
  input wire logic input_rail_ovp_raw,
  input wire logic input_rail_ovp_hys_clear,
  input wire logic input_rail_above_uvlo,
  input wire logic input_rail_below_uvlo_hys,
  input wire logic drop_alarm_raw,
  input wire logic drop_ovp_raw,
  input wire logic thermal_shutdown_raw,
  input wire logic overcurrent_raw,
  input wire logic [9:0] connector_temp_result,
  input wire logic [9:0] connector_temp_threshold,
  input wire logic [9:0] battery_temp_result,
  input wire logic [9:0] battery_temp_threshold,
  output logic switch_close,
  output logic switch_enable,
  output logic adc_run,
  output logic input_overvoltage_flag,
  output logic input_insert_flag,
  output logic drop_alarm_flag,
  output logic connector_overtemp_flag,
  output logic battery_overtemp_flag,
  output logic thermal_shutdown_flag,
  output logic overcurrent_flag,
  output logic int_n,
  output logic [2:0] hiccup_count
);
  localparam bsfp_cnt_t DGL_OVP = bsfp_cnt_t'((`BSFP_DGL_OVP_NS + `BSFP_CLK_NS - 1) / `BSFP_CLK_NS);
  localparam bsfp_cnt_t DGL_DROP = bsfp_cnt_t'((`BSFP_DGL_DROP_NS + `BSFP_CLK_NS - 1) / `BSFP_CLK_NS);
  localparam bsfp_cnt_t DGL_ALM = bsfp_cnt_t'((`BSFP_DGL_ALM_NS + `BSFP_CLK_NS - 1) / `BSFP_CLK_NS);
  localparam bsfp_cnt_t DGL_TEMP = bsfp_cnt_t'((`BSFP_DGL_TEMP_NS + `BSFP_CLK_NS - 1) / `BSFP_CLK_NS);
  localparam bsfp_cnt_t DGL_OCP = bsfp_cnt_t'((`BSFP_DGL_OCP_NS + `BSFP_CLK_NS - 1) / `BSFP_CLK_NS);

  // one qualifier per fault source except thermal shutdown and lockout, all share the same restart rule
  bsfp_dgl_if dg_ovp();
  bsfp_dgl_if dg_drop();
  bsfp_dgl_if dg_alm();
  bsfp_dgl_if dg_tbus();
  bsfp_dgl_if dg_tbat();
  bsfp_dgl_if dg_ocp();

  bsfp_state_e state_reg;
  bsfp_state_e state_next;
  logic [31:0] wait_reg;
  logic [31:0] wait_next;
  logic [2:0] retry_reg;
  logic [2:0] retry_next;
  logic en_reg;
  logic en_next;
  logic [6:0] flag_reg;
  logic [6:0] flag_set;
  logic [6:0] flag_next;
  logic ovp_hold_reg;
  logic ovp_hold_next;

  function automatic logic below_th(input logic [9:0] res, input logic [9:0] th);
    below_th = res < th;
  endfunction

  wire closed = (state_reg == BSFP_CLOSED) || (state_reg == BSFP_HICCUP_TRY);
  // temperature comparisons mean nothing while the converter is idle
  wire adc_live = adc_enable_req && !thermal_shutdown_raw;
  assign dg_ovp.raw = input_rail_ovp_raw;
  assign dg_ovp.len = DGL_OVP;
  assign dg_drop.raw = drop_ovp_raw && drop_ovp_enable;
  assign dg_drop.len = DGL_DROP;
  assign dg_alm.raw = drop_alarm_raw && closed;
  assign dg_alm.len = DGL_ALM;
  assign dg_tbus.raw = adc_live && below_th(connector_temp_result, connector_temp_threshold);
  assign dg_tbus.len = DGL_TEMP;
  assign dg_tbat.raw = adc_live && below_th(battery_temp_result, battery_temp_threshold);
  assign dg_tbat.len = DGL_TEMP;
  assign dg_ocp.raw = overcurrent_raw && closed;
  assign dg_ocp.len = DGL_OCP;

  bsfp_deglitch u_dg_ovp (.sys_clk(sys_clk), .rst_n(rst_n), .dg(dg_ovp));
  bsfp_deglitch u_dg_drop (.sys_clk(sys_clk), .rst_n(rst_n), .dg(dg_drop));
  bsfp_deglitch u_dg_alm (.sys_clk(sys_clk), .rst_n(rst_n), .dg(dg_alm));
  bsfp_deglitch u_dg_tbus (.sys_clk(sys_clk), .rst_n(rst_n), .dg(dg_tbus));
  bsfp_deglitch u_dg_tbat (.sys_clk(sys_clk), .rst_n(rst_n), .dg(dg_tbat));
  bsfp_deglitch u_dg_ocp (.sys_clk(sys_clk), .rst_n(rst_n), .dg(dg_ocp));

  wire ovp_trip = dg_ovp.hit;
  wire drop_trip = dg_drop.hit && closed;
  wire tbus_trip = dg_tbus.hit;
  wire tbat_trip = dg_tbat.hit;
  wire tsd_trip = thermal_shutdown_raw;
  wire ocp_trip = dg_ocp.hit;
  wire uvlo_fall = closed && input_rail_below_uvlo_hys;
  wire last_retry = (retry_reg == `BSFP_HICCUP_RETRIES);
  wire ocp_latch = ocp_trip && (!overcurrent_retry_mode || last_retry);
  wire ocp_hiccup = ocp_trip && overcurrent_retry_mode && !last_retry;
  wire hard_trip = ovp_trip || drop_trip || tbus_trip || tbat_trip || tsd_trip || ocp_latch;
  // a write that lands during overvoltage is undone at once
  wire en_write_ok = enable_write && enable_wdata && !input_rail_ovp_raw;
  // closing is blocked by lockout, overvoltage hysteresis and an active drop fault
  wire may_close = en_reg && input_rail_above_uvlo && !ovp_hold_reg &&
    !(drop_ovp_enable && drop_ovp_raw) && !hard_trip;

  always_comb begin
    en_next = en_reg;
    if (enable_write) begin
      en_next = en_write_ok;
    end
    if (hard_trip) begin
      en_next = 1'b0;
    end
  end

  // hold lasts until the input drops below threshold minus hysteresis
  assign ovp_hold_next = ovp_trip ? 1'b1 : (input_rail_ovp_hys_clear ? 1'b0 : ovp_hold_reg);

  assign flag_set = {ocp_latch, tsd_trip, tbat_trip, tbus_trip, dg_alm.hit, uvlo_fall,
    ovp_trip || drop_trip};
  // set wins over a clear in the same cycle
  assign flag_next = flag_set | (flag_reg & ~(flag_clear ? flag_clear_mask : 7'h00));

  always_comb begin
    state_next = state_reg;
    wait_next = wait_reg;
    retry_next = retry_reg;
    unique case (state_reg)
      BSFP_OPEN: begin
        retry_next = 3'h0;
        if (may_close) begin
          state_next = BSFP_CLOSED;
        end
      end
      BSFP_CLOSED: begin
        if (hard_trip || uvlo_fall || !en_reg) begin
          state_next = BSFP_OPEN;
        end else if (ocp_hiccup) begin
          state_next = BSFP_HICCUP_WAIT;
          wait_next = 32'h0000_0000;
          retry_next = 3'h1;
        end
      end
      BSFP_HICCUP_WAIT: begin
        wait_next = wait_reg + 32'h0000_0001;
        if (hard_trip || !en_reg) begin
          state_next = BSFP_OPEN;
        end else if (wait_reg >= HICCUP_CYCLES - 1) begin
          state_next = BSFP_HICCUP_TRY;
        end
      end
      BSFP_HICCUP_TRY: begin
        if (hard_trip || uvlo_fall || !en_reg) begin
          state_next = BSFP_OPEN;
        end else if (ocp_hiccup) begin
          state_next = BSFP_HICCUP_WAIT;
          wait_next = 32'h0000_0000;
          retry_next = retry_reg + 3'h1;
        end else if (!overcurrent_raw) begin
          state_next = BSFP_CLOSED;
        end
      end
      default: begin
        state_next = BSFP_OPEN;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg <= BSFP_OPEN;
      wait_reg <= 32'h0000_0000;
      retry_reg <= 3'h0;
      en_reg <= 1'b0;
      flag_reg <= `BSFP_FLAG_RST;
      ovp_hold_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      wait_reg <= wait_next;
      retry_reg <= retry_next;
      en_reg <= en_next;
      flag_reg <= flag_next;
      ovp_hold_reg <= ovp_hold_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      switch_close <= 1'b0;
      switch_enable <= 1'b0;
      adc_run <= 1'b0;
      int_n <= 1'b1;
      hiccup_count <= 3'h0;
      {overcurrent_flag, thermal_shutdown_flag, battery_overtemp_flag, connector_overtemp_flag,
        drop_alarm_flag, input_insert_flag, input_overvoltage_flag} <= `BSFP_FLAG_RST;
    end else begin
      switch_close <= (state_next == BSFP_CLOSED) || (state_next == BSFP_HICCUP_TRY);
      switch_enable <= en_next;
      adc_run <= adc_live;
      int_n <= ~|flag_next;
      hiccup_count <= retry_next;
      {overcurrent_flag, thermal_shutdown_flag, battery_overtemp_flag, connector_overtemp_flag,
        drop_alarm_flag, input_insert_flag, input_overvoltage_flag} <= flag_next;
    end
  end

  ovp_trip_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ovp_trip |=> !switch_close && !switch_enable && input_overvoltage_flag && !int_n)
    else $error("overvoltage trip not handled");
  self_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    enable_write && enable_wdata && input_rail_ovp_raw |=> !switch_enable)
    else $error("enable not self cleared");
  uvlo_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_reg == BSFP_OPEN && !input_rail_above_uvlo |=> !switch_close)
    else $error("switch closed under lockout");
  uvlo_fall_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    uvlo_fall && !hard_trip && en_reg && !enable_write |=> input_insert_flag && switch_enable
    && !switch_close) else $error("lockout fall wrong");
  drop_alarm_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    dg_alm.hit |=> drop_alarm_flag && !int_n) else $error("drop alarm missed");
  tsd_adc_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    thermal_shutdown_raw |=> !adc_run && thermal_shutdown_flag && !switch_enable)
    else $error("thermal shutdown wrong");
  hiccup_keep_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ocp_hiccup && !hard_trip && en_reg && !enable_write |=> switch_enable && !switch_close
    && !overcurrent_flag ##0 $stable(overcurrent_flag))
    else $error("hiccup entry wrong");
  retry_cap_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    hiccup_count <= 3'h6) else $error("too many retries");
  int_pin_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    int_n == !(|{overcurrent_flag, thermal_shutdown_flag, battery_overtemp_flag,
    connector_overtemp_flag, drop_alarm_flag, input_insert_flag, input_overvoltage_flag}))
    else $error("interrupt pin mismatch");
  ovp_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ovp_hold_reg && state_reg == BSFP_OPEN |=> !switch_close)
    else $error("switch closed during overvoltage hold");
  adc_follow_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !thermal_shutdown_raw |=> adc_run == $past(adc_enable_req))
    else $error("converter not following its enable");
  drop_trip_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    drop_trip |=> !switch_close && !switch_enable && input_overvoltage_flag && !int_n)
    else $error("drop overvoltage trip not handled");
  drop_block_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_reg == BSFP_OPEN && drop_ovp_enable && drop_ovp_raw |=> !switch_close)
    else $error("switch closed during drop fault");
  tbus_trip_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    tbus_trip |=> !switch_close && !switch_enable && connector_overtemp_flag && !int_n)
    else $error("connector overtemp not handled");
  tbat_trip_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    tbat_trip |=> !switch_close && !switch_enable && battery_overtemp_flag && !int_n)
    else $error("battery overtemp not handled");
  host_reclose_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_reg == BSFP_OPEN && !en_reg && !enable_write |=> !switch_close)
    else $error("switch reclosed without host");
  ocp_latch_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ocp_latch |=> !switch_close && !switch_enable && overcurrent_flag && !int_n)
    else $error("overcurrent latch not handled");
  hiccup_done_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_reg == BSFP_HICCUP_TRY && !overcurrent_raw && !hard_trip && !uvlo_fall && en_reg
    && !enable_write |=> switch_close && switch_enable)
    else $error("hiccup recovery wrong");
endmodule

/* bsfp_map.svh */
`ifndef BSFP_MAP_SVH
`define BSFP_MAP_SVH
// Notes on behaviour
// - input overvoltage trip opens, clears enable, flags
// - host re-enables; stays open until hysteresis clear
// - enable write during overvoltage self-clears
// - faults other than thermal shutdown leave converter following its enable
// - switch held open below lockout threshold, except at end of hiccup wait
// - lockout fall opens switch, sets insert flag
// - drop alarm flags only, switch stays closed
// - drop overvoltage opens, clears enable, flags
// - drop protection off at reset; blocks closing except at end of hiccup wait
// - connector overtemp opens, clears enable, flags
// - battery overtemp opens, clears enable, flags
// - thermal shutdown opens, flags, converter standby
// - latched overcurrent opens, clears enable, flags
// - retry mode opens, waits, recloses, enable kept
// - cleared overcurrent after retry ends silently
// - six retries in all, then flag and disable
`define BSFP_DGL_W 16
`define BSFP_DGL_OVP_NS 100
`define BSFP_DGL_DROP_NS 100
`define BSFP_DGL_ALM_NS 1000
`define BSFP_DGL_TEMP_NS 1000
`define BSFP_DGL_OCP_NS 100
`define BSFP_CLK_NS 8
`define BSFP_HICCUP_MS 100
`define BSFP_HICCUP_RETRIES 3'h6
`define BSFP_FLAG_RST 7'h00
`endif

/* bsfp_pkg.sv */
package bsfp_pkg;
  typedef enum logic [3:0] {
    BSFP_OPEN = 4'b0001,
    BSFP_CLOSED = 4'b0010,
    BSFP_HICCUP_WAIT = 4'b0100,
    BSFP_HICCUP_TRY = 4'b1000
  } bsfp_state_e;
  typedef logic [15:0] bsfp_cnt_t;
endpackage

/* bsfp_dgl_if.sv */
`timescale 1ns/100ps
interface bsfp_dgl_if;
  logic raw;
  logic [15:0] len;
  logic hit;
  modport filt (input raw, input len, output hit);
  modport user (output raw, output len, input hit);
endinterface

/* bsfp_deglitch.sv */
`timescale 1ns/100ps
`include "bsfp_map.svh"
module bsfp_deglitch
  import bsfp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  bsfp_dgl_if.filt dg
);
  bsfp_cnt_t cnt_reg;
  bsfp_cnt_t cnt_next;
  wire at_len = (cnt_reg >= dg.len);
  // restart on any deassert so short glitches never accumulate
  assign cnt_next = !dg.raw ? '0 : (at_len ? cnt_reg : cnt_reg + 16'h0001);
  assign dg.hit = dg.raw && at_len;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt_reg <= 16'h0000;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
  restart_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !dg.raw |=> cnt_reg == 16'h0000) else $error("deglitch count not restarted");
endmodule

/* bsfp_host.sv */
`timescale 1ns/100ps
module bsfp_host (
  input wire logic sys_clk,
  output logic enable_write,
  output logic enable_wdata,
  output logic flag_clear,
  output logic [6:0] flag_clear_mask
);
  initial begin
    enable_write = 1'b0;
    enable_wdata = 1'b0;
    flag_clear = 1'b0;
    flag_clear_mask = 7'h00;
  end
  // re-enable after any trip is the host's job
  task automatic write_enable(input logic v);
    enable_wdata = v;
    enable_write = 1'b1;
    @(posedge sys_clk);
    #1 enable_write = 1'b0;
  endtask
  task automatic clear_flags(input logic [6:0] m);
    flag_clear_mask = m;
    flag_clear = 1'b1;
    @(posedge sys_clk);
    #1 flag_clear = 1'b0;
  endtask
endmodule

/* bsfp_top_bench.sv */
`timescale 1ns/100ps
module bsfp_top_bench;
  import bsfp_pkg::*;
  localparam int HC = 50;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic drop_en = 1'b0, oc_mode = 1'b0, adc_en = 1'b1, ovp = 1'b0, hys = 1'b1;
  logic uv_ok = 1'b0, uv_low = 1'b0, alm = 1'b0, dovp = 1'b0, tsd = 1'b0, oc = 1'b0;
  logic [9:0] ct = 10'h3ff, bt = 10'h3ff, cth = 10'h100, bth = 10'h100;
  logic ew, ewd, fc, sc, se, ar, f0, f1, f2, f3, f4, f5, f6, int_n;
  logic [6:0] fm;
  logic [6:0] fl;
  logic [2:0] hc;
  int bad_count = 0;
  int n_checks = 0;
  assign fl = {f6, f5, f4, f3, f2, f1, f0};
  always #4 sys_clk = ~sys_clk;
  bsfp_host bsfp_host_inst (.sys_clk(sys_clk), .enable_write(ew), .enable_wdata(ewd),
    .flag_clear(fc), .flag_clear_mask(fm));
  bsfp_top #(.HICCUP_CYCLES(HC)) bsfp_top_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .enable_write(ew), .enable_wdata(ewd), .drop_ovp_enable(drop_en),
    .overcurrent_retry_mode(oc_mode), .adc_enable_req(adc_en), .flag_clear(fc),
    .flag_clear_mask(fm), .input_rail_ovp_raw(ovp), .input_rail_ovp_hys_clear(hys),
    .input_rail_above_uvlo(uv_ok), .input_rail_below_uvlo_hys(uv_low), .drop_alarm_raw(alm),
    .drop_ovp_raw(dovp), .thermal_shutdown_raw(tsd), .overcurrent_raw(oc),
    .connector_temp_result(ct), .connector_temp_threshold(cth),
    .battery_temp_result(bt), .battery_temp_threshold(bth),
    .switch_close(sc), .switch_enable(se), .adc_run(ar), .input_overvoltage_flag(f0),
    .input_insert_flag(f1), .drop_alarm_flag(f2), .connector_overtemp_flag(f3),
    .battery_overtemp_flag(f4), .thermal_shutdown_flag(f5), .overcurrent_flag(f6),
    .int_n(int_n), .hiccup_count(hc));
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [9:0] seen, input logic [9:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // int_n must follow the flags, so it is checked with every state
  task automatic chk_st(input logic e_se, input logic e_sc, input logic [6:0] e_fl);
    chk("switch_enable", {9'h000, se}, {9'h000, e_se});
    chk("switch_close", {9'h000, sc}, {9'h000, e_sc});
    chk("flags", {3'h0, fl}, {3'h0, e_fl});
    chk("int_n", {9'h000, int_n}, {9'h000, e_fl == 7'h00});
  endtask
  task automatic st(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic reopen();
    bsfp_host_inst.write_enable(1'b1);
    bsfp_host_inst.clear_flags(7'h7f);
    st(3);
  endtask
  task automatic done(input string nm);
    $display("test %s done", nm);
  endtask
  initial begin
    int k;
    st(4);
    rst_n = 1'b1;
    chk_st(1'b0, 1'b0, 7'h00);
    bsfp_host_inst.write_enable(1'b1);
    st(3);
    chk_st(1'b1, 1'b0, 7'h00);
    uv_ok = 1'b1;
    st(3);
    chk_st(1'b1, 1'b1, 7'h00);
    done("lockout");
    hys = 1'b0;
    ovp = 1'b1;
    st(10);
    ovp = 1'b0;
    st(1);
    ovp = 1'b1;
    st(10);
    chk_st(1'b1, 1'b1, 7'h00);
    st(10);
    chk_st(1'b0, 1'b0, 7'h01);
    chk("adc_run", {9'h000, ar}, 10'h001);
    bsfp_host_inst.write_enable(1'b1);
    st(2);
    chk("switch_enable", {9'h000, se}, 10'h000);
    ovp = 1'b0;
    bsfp_host_inst.write_enable(1'b1);
    st(3);
    chk_st(1'b1, 1'b0, 7'h01);
    hys = 1'b1;
    st(3);
    chk_st(1'b1, 1'b1, 7'h01);
    reopen();
    chk_st(1'b1, 1'b1, 7'h00);
    done("overvoltage");
    uv_low = 1'b1;
    uv_ok = 1'b0;
    st(3);
    chk_st(1'b1, 1'b0, 7'h02);
    uv_low = 1'b0;
    uv_ok = 1'b1;
    st(3);
    chk_st(1'b1, 1'b1, 7'h02);
    bsfp_host_inst.clear_flags(7'h7f);
    alm = 1'b1;
    st(140);
    chk_st(1'b1, 1'b1, 7'h04);
    alm = 1'b0;
    bsfp_host_inst.clear_flags(7'h7f);
    done("lockout fall and alarm");
    dovp = 1'b1;
    st(20);
    chk_st(1'b1, 1'b1, 7'h00);
    drop_en = 1'b1;
    st(20);
    chk_st(1'b0, 1'b0, 7'h01);
    bsfp_host_inst.write_enable(1'b1);
    st(3);
    chk("switch_close", {9'h000, sc}, 10'h000);
    dovp = 1'b0;
    reopen();
    chk_st(1'b1, 1'b1, 7'h00);
    done("drop");
    adc_en = 1'b0;
    ct = 10'h0ff;
    st(140);
    chk_st(1'b1, 1'b1, 7'h00);
    chk("adc_run", {9'h000, ar}, 10'h000);
    ct = 10'h3ff;
    adc_en = 1'b1;
    st(2);
    for (int i = 0; i < 2; i++) begin
      if (i == 0) ct = 10'h0ff;
      else begin
        bth = 10'h300;
        bt = 10'h2ff;
      end
      st(140);
      chk_st(1'b0, 1'b0, (i == 0) ? 7'h08 : 7'h10);
      chk("adc_run", {9'h000, ar}, 10'h001);
      ct = 10'h3ff;
      bt = 10'h3ff;
      reopen();
      chk_st(1'b1, 1'b1, 7'h00);
    end
    done("temperature");
    tsd = 1'b1;
    st(3);
    chk_st(1'b0, 1'b0, 7'h20);
    chk("adc_run", {9'h000, ar}, 10'h000);
    tsd = 1'b0;
    st(3);
    chk_st(1'b0, 1'b0, 7'h20);
    reopen();
    chk_st(1'b1, 1'b1, 7'h00);
    done("thermal");
    oc = 1'b1;
    st(20);
    oc = 1'b0;
    chk_st(1'b0, 1'b0, 7'h40);
    reopen();
    oc_mode = 1'b1;
    oc = 1'b1;
    st(20);
    chk_st(1'b1, 1'b0, 7'h00);
    chk("hiccup_count", {7'h00, hc}, 10'h001);
    oc = 1'b0;
    k = 0;
    while (sc !== 1'b1 && k < HC + 40) begin
      st(1);
      k++;
    end
    if (k >= HC + 40) wrap_up();
    chk("hiccup_wait", {9'h000, k >= HC - 10}, 10'h001);
    chk_st(1'b1, 1'b1, 7'h00);
    done("hiccup recover");
    oc = 1'b1;
    st(200);
    chk("switch_enable", {9'h000, se}, 10'h001);
    chk("flags", {3'h0, fl}, 10'h000);
    st(500);
    chk_st(1'b0, 1'b0, 7'h40);
    done("hiccup exhaust");
    wrap_up();
  end
endmodule
